// ==== src/i2cs_core.sv ====
// What this block does
// R1: Status register is read-only; its value serves as a service vector.
// R2: Own address received with acknowledge enabled sets interrupt and acks.
// R3: General call acked and interrupts only if address bit 0 and ack enabled.
// R4: Master mode byte done, even with arbitration lost, sets interrupt.
// R5: Selected slave sets interrupt after each byte received or sent.
// R6: Stop while selected slave sets interrupt flag as stop interrupt.
// R7: Reading the status register clears the interrupt flag, bit 5.
// R8: Stop condition on the bus sets stop flag, bit 6.
// R9: Bit 4 is one while acting as transmitter.
// R10: Bit 3 is one while another master uses the bus.
// R11: Bit 2 is one after losing arbitration as master.
// R12: Bit 1 is one on not-acknowledge, zero on acknowledge.
// R13: Bit 0 is one while in slave mode.
// R14: Bit 7 is one when general call, not own address, was acked.
// R15: Data register holds next byte to send or last byte received.
// R16: Data shifts toward the top; bit 7 goes first on the bus.
// R17: Own seven-bit address sits in bits 7..1; slave answers that and, with bit 0 set, the general call.
// R18: Hold-time setup register at D2h, reset 00h, used in slave mode.
// R19: Setup bit 7 clear means one sample, bits 6..0 ignored.
// R20: Setup bit 7 set needs bits 6..0 plus one samples at fosc/2.
// R21: Software programs 8Bh at 40 MHz for 600 ns hold time.
// R22: Acknowledge enable pulls SDA low in ack clock, else releases it.
`timescale 1ns/1ps
module i2cs_core
    import i2cs_pkg::*;
#(
    parameter int FW = FIFO_W,
    parameter int FD = FIFO_D
) (
    input  wire logic          mclk,
    input  wire logic          resetn,
    input  wire logic [7:0]    sfr_addr,
    input  wire logic [7:0]    sfr_wdata,
    input  wire logic          sfr_wr,
    input  wire logic          sfr_rd,
    output logic [7:0]         sfr_rdata,
    input  wire logic          acknowledge_enable,
    input  wire logic          master_active,
    input  wire logic          master_tx,
    input  wire logic          master_byte_done,
    input  wire logic          master_arb_lost,
    input  wire logic          scl_in,
    output logic               scl_out,
    output logic               scl_oe_n,
    input  wire logic          sda_in,
    output logic               sda_out,
    output logic               sda_oe_n,
    output logic [FW-1:0]      rx_data,
    output logic               rx_valid,
    input  wire logic          rx_ready
);
    // ==========================================================
    // Registers and state
    // ==========================================================
    logic [7:0]  hold_time_detect_setup_reg;
    logic [7:0]  own_slave_address_reg;
    logic [7:0]  serial_data_shift_reg;
    i2cs_state_e state_reg;
    logic [3:0]  bit_reg;
    logic        ack_drv_reg;
    logic        tx_wait_reg;
    logic        pend_reg;
    logic        slv_evt_reg;
    logic        slave_role_flag_reg;
    logic        slv_tx_reg;
    logic        general_call_flag_reg;
    logic        interrupt_flag_reg;
    logic        stop_flag_reg;
    logic        other_master_active_reg;
    logic        arbitration_lost_reg;
    logic        nack_seen_reg;
    logic        master_q_reg;
    logic        samp_div_reg;
    logic [1:0]  filt_reg;
    logic [1:0]  filt_q_reg;
    logic [6:0]  hold_cnt_reg [2];
    logic [7:0]  bus_status;
    logic [6:0]  hold_limit;
    logic        samp_en;
    logic        scl_f;
    logic        sda_f;
    logic        start_det;
    logic        stop_det;
    logic        scl_rise;
    logic        scl_fall;
    logic        st_rd;
    logic        fifo_ready;
    logic        own_hit;
    logic        gc_hit;

    // ==========================================================
    // Start/stop hold-time filter
    // ==========================================================
    // Each line has its own filter; both use one hold limit, so start and stop see the same delay.
    assign samp_en    = samp_div_reg;
    assign hold_limit = hold_time_detect_setup_reg[SETUP_EN]
                        ? hold_time_detect_setup_reg[6:0] : 7'h00; // [R19]
    assign scl_f = filt_reg[0];
    assign sda_f = filt_reg[1];

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            samp_div_reg <= 1'b0;
        end else begin
            samp_div_reg <= !samp_div_reg;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_filt
            logic raw;
            assign raw = (gi == 0) ? scl_in : sda_in;
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    filt_reg[gi]     <= 1'b1;
                    hold_cnt_reg[gi] <= 7'h00;
                end else if (raw == filt_reg[gi]) begin
                    hold_cnt_reg[gi] <= 7'h00;
                end else if (samp_en) begin
                    if (hold_cnt_reg[gi] == hold_limit) begin // [R20]
                        filt_reg[gi]     <= raw;
                        hold_cnt_reg[gi] <= 7'h00;
                    end else begin
                        hold_cnt_reg[gi] <= hold_cnt_reg[gi] + 7'h01;
                    end
                end
            end
            a_hold_count: assert property (@(posedge mclk)
                disable iff (!resetn)
                $changed(filt_reg[gi]) |->
                $past(hold_cnt_reg[gi]) == $past(hold_limit))
                else $error("line changed before hold count"); // [R20]
        end
    endgenerate

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            filt_q_reg   <= 2'b11;
            master_q_reg <= 1'b0;
        end else begin
            filt_q_reg   <= filt_reg;
            master_q_reg <= master_active;
        end
    end

    assign scl_rise  = scl_f && !filt_q_reg[0];
    assign scl_fall  = !scl_f && filt_q_reg[0];
    assign start_det = scl_f && filt_q_reg[0] && !sda_f && filt_q_reg[1];
    assign stop_det  = scl_f && filt_q_reg[0] && sda_f && !filt_q_reg[1];

    // ==========================================================
    // Register access
    // ==========================================================
    assign st_rd = sfr_rd && (sfr_addr == ADDR_STATUS);
    assign bus_status = {general_call_flag_reg, stop_flag_reg,
                         interrupt_flag_reg, slv_tx_reg | master_tx,
                         other_master_active_reg, arbitration_lost_reg,
                         nack_seen_reg, slave_role_flag_reg}; // [R1]

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hold_time_detect_setup_reg <= HOLD_SETUP_RST; // [R18]
            own_slave_address_reg      <= OWN_ADDR_RST;
        end else if (sfr_wr) begin
            if (sfr_addr == ADDR_HOLD_SETUP) begin
                hold_time_detect_setup_reg <= sfr_wdata;
            end
            if (sfr_addr == ADDR_OWN) begin
                own_slave_address_reg <= sfr_wdata;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            unique case (sfr_addr)
                ADDR_HOLD_SETUP: sfr_rdata <= hold_time_detect_setup_reg;
                ADDR_STATUS:     sfr_rdata <= bus_status;
                ADDR_DATA:       sfr_rdata <= serial_data_shift_reg;
                ADDR_OWN:        sfr_rdata <= own_slave_address_reg;
                default:         sfr_rdata <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Slave byte engine
    // ==========================================================
    assign own_hit = serial_data_shift_reg[7:1] ==
                     own_slave_address_reg[7:1]; // [R17]
    assign gc_hit  = serial_data_shift_reg == 8'h00 &&
                     own_slave_address_reg[OWN_GCEN]; // [R3]

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg             <= S_IDLE;
            bit_reg               <= 4'h0;
            ack_drv_reg           <= 1'b0;
            tx_wait_reg           <= 1'b0;
            pend_reg              <= 1'b0;
            slv_evt_reg           <= 1'b0;
            slave_role_flag_reg   <= 1'b0;
            slv_tx_reg            <= 1'b0;
            general_call_flag_reg <= 1'b0;
            nack_seen_reg         <= 1'b0;
            serial_data_shift_reg <= DATA_RST;
        end else begin
            slv_evt_reg <= 1'b0;
            if (pend_reg && fifo_ready) begin
                pend_reg <= 1'b0;
            end
            if (sfr_wr && sfr_addr == ADDR_DATA) begin
                serial_data_shift_reg <= sfr_wdata; // [R15]
                tx_wait_reg           <= 1'b0;
            end
            if (start_det) begin
                state_reg   <= S_ADDR;
                bit_reg     <= 4'h0;
                ack_drv_reg <= 1'b0;
                tx_wait_reg <= 1'b0;
            end else if (stop_det) begin
                state_reg           <= S_IDLE;
                ack_drv_reg         <= 1'b0;
                tx_wait_reg         <= 1'b0;
                slave_role_flag_reg <= 1'b0;
                slv_tx_reg          <= 1'b0;
            end else if (scl_rise) begin
                unique case (state_reg)
                    S_ADDR, S_RXD: begin
                        serial_data_shift_reg <=
                            {serial_data_shift_reg[6:0], sda_f}; // [R16]
                        bit_reg <= bit_reg + 4'h1;
                    end
                    S_TXD: bit_reg <= bit_reg + 4'h1;
                    S_TX_ACK: nack_seen_reg <= sda_f; // [R12]
                    S_RX_ACK: nack_seen_reg <= !ack_drv_reg; // [R12]
                    default: ;
                endcase
            end else if (scl_fall) begin
                unique case (state_reg)
                    S_ADDR: if (bit_reg == BYTE_BITS) begin
                        if (acknowledge_enable && (own_hit || gc_hit)) begin
                            state_reg             <= S_ADDR_ACK;
                            ack_drv_reg           <= 1'b1; // [R2] [R22]
                            slv_evt_reg           <= 1'b1; // [R2] [R3]
                            slave_role_flag_reg   <= 1'b1; // [R13]
                            slv_tx_reg <= serial_data_shift_reg[0]; // [R9]
                            general_call_flag_reg <=
                                gc_hit && !own_hit; // [R14]
                        end else begin
                            state_reg <= S_IDLE;
                        end
                    end
                    S_ADDR_ACK: begin
                        ack_drv_reg <= 1'b0;
                        bit_reg     <= 4'h0;
                        state_reg   <= slv_tx_reg ? S_TXD : S_RXD;
                        tx_wait_reg <= slv_tx_reg;
                    end
                    S_TXD: if (bit_reg == BYTE_BITS) begin
                        state_reg   <= S_TX_ACK;
                        slv_evt_reg <= 1'b1; // [R5]
                    end else begin
                        serial_data_shift_reg <=
                            {serial_data_shift_reg[6:0], 1'b0}; // [R16]
                    end
                    S_TX_ACK: begin
                        bit_reg     <= 4'h0;
                        state_reg   <= nack_seen_reg ? S_IDLE : S_TXD;
                        tx_wait_reg <= !nack_seen_reg;
                    end
                    S_RXD: if (bit_reg == BYTE_BITS) begin
                        state_reg   <= S_RX_ACK;
                        ack_drv_reg <= acknowledge_enable; // [R22]
                        slv_evt_reg <= 1'b1; // [R5]
                        pend_reg    <= 1'b1;
                    end
                    S_RX_ACK: begin
                        ack_drv_reg <= 1'b0;
                        bit_reg     <= 4'h0;
                        state_reg   <= ack_drv_reg ? S_RXD : S_IDLE;
                    end
                    default: ;
                endcase
            end
        end
    end

    a_gc_gated: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(general_call_flag_reg) |->
        $past(own_slave_address_reg[OWN_GCEN] && acknowledge_enable))
        else $error("general call flag without enables"); // [R3]

    a_ack_drive: assert property (@(posedge mclk) disable iff (!resetn)
        state_reg == S_ADDR_ACK && !scl_f |-> !sda_oe_n)
        else $error("address not acknowledged on sda"); // [R22]

    a_msb_first: assert property (@(posedge mclk) disable iff (!resetn)
        state_reg == S_TXD && bit_reg != BYTE_BITS |->
        sda_oe_n == serial_data_shift_reg[7])
        else $error("transmit bit is not data bit 7"); // [R16]

    // ==========================================================
    // Status flags
    // ==========================================================
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            interrupt_flag_reg <= 1'b0;
        end else if (slv_evt_reg || master_byte_done || master_arb_lost
                     || (stop_det && slave_role_flag_reg)) begin
            interrupt_flag_reg <= 1'b1; // [R4] [R5] [R6]
        end else if (st_rd) begin
            interrupt_flag_reg <= 1'b0; // [R7]
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            stop_flag_reg <= 1'b0;
        end else if (stop_det) begin
            stop_flag_reg <= 1'b1; // [R8]
        end else if (start_det) begin
            stop_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            other_master_active_reg <= 1'b0;
        end else if (stop_det || master_active) begin
            other_master_active_reg <= 1'b0;
        end else if (start_det) begin
            other_master_active_reg <= 1'b1; // [R10]
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            arbitration_lost_reg <= 1'b0;
        end else if (master_arb_lost) begin
            arbitration_lost_reg <= 1'b1; // [R11]
        end else if (master_active && !master_q_reg) begin
            arbitration_lost_reg <= 1'b0;
        end
    end

    a_interrupt_flag_clear: assert property (@(posedge mclk) disable iff (!resetn)
        st_rd && !slv_evt_reg && !master_byte_done && !master_arb_lost
        && !stop_det |=> !interrupt_flag_reg)
        else $error("status read left interrupt flag set"); // [R7]

    a_master_interrupt_flag: assert property (@(posedge mclk) disable iff (!resetn)
        master_byte_done || master_arb_lost |=> interrupt_flag_reg)
        else $error("master byte gave no interrupt"); // [R4]

    a_stop_interrupt_flag: assert property (@(posedge mclk) disable iff (!resetn)
        stop_det && slave_role_flag_reg |=>
        interrupt_flag_reg && stop_flag_reg && !slave_role_flag_reg)
        else $error("slave stop not flagged"); // [R6]

    a_stop_flag: assert property (@(posedge mclk) disable iff (!resetn)
        stop_det |=> bus_status[ST_STOP])
        else $error("stop flag not set"); // [R8]

    a_busy_start: assert property (@(posedge mclk) disable iff (!resetn)
        start_det && !master_active ##1 !master_active && !stop_det
        |-> bus_status[ST_BUSY] ##1 bus_status[ST_BUSY])
        else $error("bus busy not held after start"); // [R10]

    a_lost_flag: assert property (@(posedge mclk) disable iff (!resetn)
        master_arb_lost |=> bus_status[ST_LOST] && bus_status[ST_INTERRUPT_FLAG])
        else $error("arbitration loss not flagged"); // [R11]

    // ==========================================================
    // Receive buffer and pins
    // ==========================================================
    // A full buffer holds SCL low, so no received byte is ever dropped.
    i2cs_fifo #(
        .W (FW),
        .D (FD)
    ) u_rx_fifo (
        .mclk      (mclk),
        .resetn    (resetn),
        .in_data   (serial_data_shift_reg),
        .in_valid  (pend_reg),
        .in_ready  (fifo_ready),
        .out_data  (rx_data),
        .out_valid (rx_valid),
        .out_ready (rx_ready)
    );

    // The bus pins are open drain; only a low level is ever driven.
    assign scl_out  = 1'b0;
    assign sda_out  = 1'b0;
    assign scl_oe_n = !(!scl_f && (pend_reg || tx_wait_reg));
    assign sda_oe_n = !(((state_reg == S_ADDR_ACK || state_reg == S_RX_ACK)
                         && ack_drv_reg) ||
                        (state_reg == S_TXD && bit_reg != BYTE_BITS &&
                         !serial_data_shift_reg[7]));
endmodule

// ==== include/i2cs_pkg.sv ====
package i2cs_pkg;
    // ==========================================================
    // Register addresses
    // ==========================================================
    localparam logic [7:0] ADDR_HOLD_SETUP = 8'hd2;
    localparam logic [7:0] ADDR_STATUS     = 8'hd3;
    localparam logic [7:0] ADDR_DATA       = 8'hd4;
    localparam logic [7:0] ADDR_OWN        = 8'hd5;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] HOLD_SETUP_RST = 8'h00;
    localparam logic [7:0] OWN_ADDR_RST   = 8'h00;
    localparam logic [7:0] DATA_RST       = 8'h00;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int ST_GC    = 7;
    localparam int ST_STOP  = 6;
    localparam int ST_INTERRUPT_FLAG  = 5;
    localparam int ST_TX    = 4;
    localparam int ST_BUSY  = 3;
    localparam int ST_LOST  = 2;
    localparam int ST_NACK  = 1;
    localparam int ST_SLV   = 0;
    localparam int SETUP_EN = 7;
    localparam int OWN_GCEN = 0;

    // ==========================================================
    // Counts
    // ==========================================================
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 16;

    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_ADDR_ACK, S_RXD, S_RX_ACK, S_TXD, S_TX_ACK
    } i2cs_state_e;
endpackage

// ==== src/i2cs_fifo.sv ====
`timescale 1ns/1ps
module i2cs_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic         mclk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0]  wr_reg;
    logic [AW:0]  rd_reg;
    logic         full;
    logic         empty;

    assign empty     = (wr_reg == rd_reg);
    assign full      = (wr_reg[AW-1:0] == rd_reg[AW-1:0]) && !empty;
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_reg[AW-1:0]];

    always_ff @(posedge mclk) begin
        if (in_valid && !full) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            if (in_valid && !full) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (out_ready && !empty) begin
                rd_reg <= rd_reg + 1'b1;
            end
        end
    end
endmodule

// ==== verif/i2cs_bus_master.sv ====
`timescale 1ns/1ps
// ==========================================
// Bus master on the far side of the wires
// ==========================================
module i2cs_bus_master #(
    parameter int Q = 10
) (
    input  wire logic mclk,
    input  wire logic scl,
    input  wire logic sda,
    output logic      m_scl,
    output logic      m_sda
);
    initial begin
        m_scl = 1'b1;
        m_sda = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic rise();
        int n;
        n = 0;
        m_scl = 1'b1;
        // The slave may stretch the clock, so follow the wire itself.
        while (scl !== 1'b1 && n < 2000) begin
            @(negedge mclk);
            n++;
        end
        w(Q);
    endtask
    task automatic glitch(input int n);
        m_sda = 1'b0;
        w(n);
        m_sda = 1'b1;
        w(Q);
    endtask
    task automatic start();
        m_sda = 1'b0;
        w(Q);
        m_scl = 1'b0;
        w(Q);
    endtask
    task automatic stop();
        m_sda = 1'b0;
        w(Q);
        rise();
        m_sda = 1'b1;
        w(Q);
    endtask
    task automatic write_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            m_sda = b[i];
            w(Q);
            rise();
            m_scl = 1'b0;
        end
        m_sda = 1'b1;
        w(Q);
        rise();
        ack = sda;
        m_scl = 1'b0;
        w(Q);
    endtask
    task automatic read_byte(input logic nack, output logic [7:0] b);
        m_sda = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            w(Q);
            rise();
            b[i] = sda;
            m_scl = 1'b0;
        end
        m_sda = nack;
        w(Q);
        rise();
        m_scl = 1'b0;
        w(Q);
        m_sda = 1'b1;
    endtask
endmodule

// ==== verif/i2c_status_data_addr_holdtime_tb.sv ====
`timescale 1ns/1ps
module i2c_status_data_addr_holdtime_tb
    import i2cs_pkg::*;
;
    logic       mclk = 1'b0, resetn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic       acknowledge_enable = 1'b1, master_active = 1'b0;
    logic       master_tx = 1'b0, master_byte_done = 1'b0, rx_ready = 1'b0;
    logic       master_arb_lost = 1'b0, rx_valid, scl_oe_n, sda_oe_n;
    logic       m_scl, m_sda, ack;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rx_data, s;
    wire        scl = m_scl & scl_oe_n;
    wire        sda = m_sda & sda_oe_n;
    int         bad_count = 0, check_count = 0;

    always #50 mclk = ~mclk;

    i2cs_core i_dut (.mclk(mclk), .resetn(resetn), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .acknowledge_enable(acknowledge_enable),
        .master_active(master_active), .master_tx(master_tx),
        .master_byte_done(master_byte_done),
        .master_arb_lost(master_arb_lost), .scl_in(scl), .scl_out(),
        .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(), .sda_oe_n(sda_oe_n),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));
    i2cs_bus_master i_master (.mclk(mclk), .scl(scl), .sda(sda),
        .m_scl(m_scl), .m_sda(m_sda));

    // ==========================================
    // Shared tasks
    // ==========================================
    task automatic chk(input string n, input logic [7:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(negedge mclk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge mclk);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge mclk);
        sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask
    task automatic st(input logic [7:0] m, exp);
        rd(ADDR_STATUS, s);
        chk("status", s & m, exp);
    endtask
    task automatic xfer(input logic [7:0] b, input logic a);
        i_master.write_byte(b, ack);
        chk("ack", {7'h00, ack}, {7'h00, a});
    endtask
    task automatic pulse(ref logic p);
        @(negedge mclk);
        p = 1'b1;
        @(negedge mclk);
        p = 1'b0;
    endtask

    // ==========================================
    // Scenarios
    // ==========================================
    task automatic t_reset();
        rd(ADDR_HOLD_SETUP, s);
        chk("setup", s, 8'h00);
        rd(ADDR_OWN, s);
        chk("own", s, 8'h00);
        rd(8'hf0, s);
        chk("unmapped", s, 8'h00);
        st(8'hff, 8'h00);
    endtask
    task automatic t_filter();
        wr(ADDR_HOLD_SETUP, 8'h8b);
        rd(ADDR_HOLD_SETUP, s);
        chk("setup", s, 8'h8b);
        i_master.glitch(10);
        st(8'h40, 8'h00);
        wr(ADDR_HOLD_SETUP, 8'h00);
        i_master.glitch(10);
        wr(ADDR_STATUS, 8'hff);
        st(8'hff, 8'h40);
    endtask
    task automatic t_write();
        wr(ADDR_OWN, 8'hb4);
        i_master.start();
        xfer(8'hb4, 1'b0);
        st(8'hff, 8'h29);
        st(8'hff, 8'h09);
        xfer(8'hc3, 1'b0);
        chk("rx", rx_data, 8'hc3);
        st(8'hff, 8'h29);
        pulse(rx_ready);
        i_master.stop();
        st(8'hff, 8'h60);
    endtask
    task automatic t_refuse();
        i_master.start();
        xfer(8'h66, 1'b1);
        i_master.stop();
        st(8'hff, 8'h40);
        i_master.start();
        xfer(8'h00, 1'b1);
        i_master.stop();
        st(8'hff, 8'h40);
        acknowledge_enable = 1'b0;
        i_master.start();
        xfer(8'hb4, 1'b1);
        i_master.stop();
        st(8'h20, 8'h00);
        acknowledge_enable = 1'b1;
    endtask
    task automatic t_gc_tx();
        wr(ADDR_OWN, 8'hb5);
        i_master.start();
        xfer(8'h00, 1'b0);
        st(8'hff, 8'ha9);
        i_master.stop();
        i_master.start();
        xfer(8'hb5, 1'b0);
        st(8'hff, 8'h39);
        wr(ADDR_DATA, 8'ha5);
        i_master.read_byte(1'b1, s);
        chk("tx", s, 8'ha5);
        st(8'h22, 8'h22);
        i_master.stop();
    endtask
    task automatic t_master();
        master_active = 1'b1;
        master_tx = 1'b1;
        pulse(master_arb_lost);
        // The not-acknowledge bit still holds the refusal of the last read.
        st(8'h3f, 8'h36);
        pulse(master_byte_done);
        st(8'h20, 8'h20);
        master_active = 1'b0;
        master_tx = 1'b0;
    endtask
    task automatic t_fifo();
        i_master.start();
        xfer(8'hb4, 1'b0);
        for (int i = 0; i < 16; i++) xfer(8'h10 + 8'(i), 1'b0);
        fork
            xfer(8'h20, 1'b0);
            begin
                repeat (400) @(negedge mclk);
                for (int k = 0; k < 17; k++) begin
                    for (int n = 0; n < 2000 && rx_valid !== 1'b1; n++)
                        @(negedge mclk);
                    chk("rx", rx_data, 8'h10 + 8'(k));
                    pulse(rx_ready);
                end
            end
        join
        i_master.stop();
        chk("empty", {7'h00, rx_valid}, 8'h00);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge mclk);
        bad_count++;
        results();
    end
    initial begin
        repeat (6) @(negedge mclk);
        resetn = 1'b1;
        t_reset();
        t_filter();
        t_write();
        t_refuse();
        t_gc_tx();
        t_master();
        t_fifo();
        results();
    end
endmodule
